// [design/flag_latch.sv]
// Bank of sticky flags where a set in the same cycle beats a clear
`timescale 1ns/10ps
module flag_latch #(
	parameter int WIDTH = 11
) (
	input wire logic clk_i, // System clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic [WIDTH-1:0] set_i, // Per-flag set pulses
	input wire logic [WIDTH-1:0] clear_i, // Per-flag clear pulses
	output logic [WIDTH-1:0] flags_o // Current flag values
);

	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] flags_nxt;

	always_comb
	begin
		flags_nxt = (flags_r & ~clear_i) | set_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			flags_r <= '0;
		end
		else
		begin
			flags_r <= flags_nxt;
		end
	end

	assign flags_o = flags_r;

endmodule

// [design/sensor_status_pkg.sv]
// Shared constants and carrier types for the channel 3 divider and status register block
package sensor_status_pkg;

	// ==========================================================
	// Register bus
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] RESULT_BASE_OFFSET = 8'h00;
	localparam logic [7:0] DIV3_OFFSET = 8'h17;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;
	localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h19;
	localparam logic [7:0] MODE_OFFSET = 8'h1a;

	// ==========================================================
	// Divider register fields
	localparam int FIN_DIV_LSB = 12;
	localparam int FIN_DIV_W = 4;
	localparam int FREF_DIV_LSB = 0;
	localparam int FREF_DIV_W = 10;
	localparam logic [15:0] DIV3_RESET = 16'h0000;

	// ==========================================================
	// Status register fields, also the layout of the enable register
	localparam int SRC_LSB = 14;
	localparam int ERR_LSB = 8;
	localparam int ERR_W = 6;
	localparam int UNDERRANGE_BIT = 13;
	localparam int OVERRANGE_BIT = 12;
	localparam int TIMEOUT_BIT = 11;
	localparam int AMP_HIGH_BIT = 10;
	localparam int AMP_LOW_BIT = 9;
	localparam int ZERO_COUNT_BIT = 8;
	localparam int READY_BIT = 6;
	localparam int PEND_LSB = 0;
	localparam int NUM_CHAN = 4;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] IRQ_ENABLE_MASK = 16'h3f4f;
	localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;

	// ==========================================================
	// Conversion mode register fields
	localparam int MODE_ACTIVE_LSB = 0;
	localparam int MODE_SEQ_BIT = 4;
	localparam logic [15:0] MODE_MASK = 16'h001f;
	localparam logic [15:0] MODE_RESET = 16'h0001;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic underrange;
		logic overrange;
		logic timeout;
		logic amp_high;
		logic amp_low;
		logic zero_count;
	} err_flags_type;

	typedef struct packed {
		logic done;
		logic [1:0] chan;
		err_flags_type err;
		logic [15:0] data;
	} conv_event_type;

endpackage

// [design/sensor_status_regs.sv]
// Channel 3 clock dividers, flag and error status, interrupt and result registers
// Overview of operation
// - Divider bits 15:12 divide sensor frequency for channel 3; zero is reserved.
// - Divider bits 9:0 divide the device clock into channel 3 reference; zero reserved.
// - Status bits 15:14 name the channel that raised the reported flag.
// - Errors stay latched until status read or source channel result read.
// - Status bit 13 reports an under-range error from an active channel.
// - Status bit 12 reports an over-range error from an active channel.
// - Status bit 11 reports a watchdog timeout from an active channel.
// - Status bit 10 reports an amplitude-high error from an active channel.
// - Status bit 9 reports an amplitude-low error from an active channel.
// - Status bit 8 reports a zero-count error from an active channel.
// - Single mode: status bit 6 sets once one new result exists.
// - Sequential mode: ready sets only after every active channel has new results.
// - Status bits 3..0 show unread results of channels 0..3.
// - Errors and ready update status only when their enable bit is set; unread bits set regardless; interrupt needs the enable bit.
`timescale 1ns/10ps
module sensor_status_regs (
	input wire logic clk_i, // System clock, 50 MHz
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic [7:0] addr_i, // Register address
	input wire logic [15:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [15:0] rd_data_o, // Read data, valid the cycle after rd_i
	input wire sensor_status_pkg::conv_event_type conv_i, // Conversion core events
	input wire logic sensor3_i, // Channel 3 sensor oscillation
	output logic ch3_fin_tick_o, // Channel 3 divided input tick
	output logic ch3_fref_tick_o, // Channel 3 reference tick
	output logic interrupt_out_n_o // Interrupt, active low
);

	// ==========================================================
	// Register storage
	logic [15:0] div3_r;
	logic [15:0] div3_nxt;
	logic [15:0] irq_en_r;
	logic [15:0] irq_en_nxt;
	logic [15:0] mode_r;
	logic [15:0] mode_nxt;
	logic [15:0] result_r [sensor_status_pkg::NUM_CHAN];
	logic [1:0] source_r;
	logic [1:0] source_nxt;
	logic [3:0] seen_r;
	logic [3:0] seen_nxt;
	logic [15:0] rd_data_r;
	logic [15:0] rd_data_nxt;
	logic irq_n_r;
	logic irq_n_nxt;
	logic sensor_prev_r;

	logic [10:0] flag_set;
	logic [10:0] flag_clear;
	logic [10:0] flags;
	logic [15:0] status_word;
	logic [5:0] err_vec;
	logic [5:0] err_rep;
	logic [3:0] active_mask;
	logic [3:0] chan_bit;
	logic chan_active;
	logic seq_mode;
	logic ready_rep;
	logic seq_complete;
	logic status_rd;
	logic result_rd;
	logic [1:0] result_ch;

	// Status bit 3 belongs to channel 0, bit 0 to channel 3
	function automatic logic [1:0] pend_index(input logic [1:0] chan);
		pend_index = 2'h3 - chan;
	endfunction

	function automatic logic [15:0] build_status(input logic [1:0] src,
		input logic [10:0] f);
		logic [15:0] s;
		s = sensor_status_pkg::STATUS_RESET;
		s[sensor_status_pkg::SRC_LSB +: 2] = src;
		s[sensor_status_pkg::ERR_LSB +: sensor_status_pkg::ERR_W] = f[10:5];
		s[sensor_status_pkg::READY_BIT] = f[4];
		s[sensor_status_pkg::PEND_LSB +: sensor_status_pkg::NUM_CHAN] = f[3:0];
		build_status = s;
	endfunction

	// ==========================================================
	// Decode
	always_comb
	begin
		err_vec = conv_i.err;
		active_mask = mode_r[sensor_status_pkg::MODE_ACTIVE_LSB +: 4];
		seq_mode = mode_r[sensor_status_pkg::MODE_SEQ_BIT];
		chan_bit = 4'h1 << conv_i.chan;
		chan_active = |(chan_bit & active_mask);
		status_rd = rd_i && (addr_i == sensor_status_pkg::STATUS_OFFSET);
		result_rd = rd_i && (addr_i[7:2] == sensor_status_pkg::RESULT_BASE_OFFSET[7:2]);
		result_ch = addr_i[1:0];
		status_word = build_status(source_r, flags);
	end

	// ==========================================================
	// Event reporting
	always_comb
	begin
		// Errors only count from active channels and only when enabled
		err_rep = err_vec & irq_en_r[sensor_status_pkg::ERR_LSB +: sensor_status_pkg::ERR_W]
			& {6{chan_active}};
		seen_nxt = (conv_i.done && chan_active) ? (seen_r | chan_bit) : seen_r;
		seq_complete = 1'b0;
		if (seq_mode && ((seen_nxt & active_mask) == active_mask) && (active_mask != 4'h0))
		begin
			seq_complete = 1'b1;
			seen_nxt = 4'h0;
		end
		ready_rep = seq_mode ? seq_complete : (conv_i.done && chan_active);
		ready_rep = ready_rep && irq_en_r[sensor_status_pkg::READY_BIT];

		source_nxt = source_r;
		if ((err_rep != 6'h00) || ready_rep)
		begin
			source_nxt = conv_i.chan;
		end

		flag_set = '0;
		flag_set[10:5] = err_rep;
		flag_set[4] = ready_rep;
		if (conv_i.done && chan_active)
		begin
			flag_set[pend_index(conv_i.chan)] = 1'b1;
		end

		flag_clear = '0;
		// A status read empties errors and ready; a result read of the source empties errors and its unread bit, not ready
		if (status_rd || (result_rd && (result_ch == source_r)))
		begin
			flag_clear[10:5] = 6'h3f;
		end
		flag_clear[4] = status_rd;
		if (result_rd)
		begin
			flag_clear[pend_index(result_ch)] = 1'b1;
		end
	end

	flag_latch #(
		.WIDTH(11)
	) status_flags (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.set_i(flag_set),
		.clear_i(flag_clear),
		.flags_o(flags)
	);

	// ==========================================================
	// Register writes and reads
	always_comb
	begin
		div3_nxt = div3_r;
		irq_en_nxt = irq_en_r;
		mode_nxt = mode_r;
		rd_data_nxt = 16'h0000;
		if (wr_i)
		begin
			case (addr_i)
				// Reserved bits 11:10 are kept as written; host keeps them zero
				sensor_status_pkg::DIV3_OFFSET: div3_nxt = wdata_i;
				sensor_status_pkg::IRQ_ENABLE_OFFSET:
					irq_en_nxt = wdata_i & sensor_status_pkg::IRQ_ENABLE_MASK;
				sensor_status_pkg::MODE_OFFSET: mode_nxt = wdata_i & sensor_status_pkg::MODE_MASK;
				default: div3_nxt = div3_r; // Status is read-only
			endcase
		end
		if (rd_i)
		begin
			if (result_rd)
			begin
				rd_data_nxt = result_r[result_ch];
			end
			else
			begin
				case (addr_i)
					sensor_status_pkg::DIV3_OFFSET: rd_data_nxt = div3_r;
					sensor_status_pkg::STATUS_OFFSET: rd_data_nxt = status_word;
					sensor_status_pkg::IRQ_ENABLE_OFFSET: rd_data_nxt = irq_en_r;
					sensor_status_pkg::MODE_OFFSET: rd_data_nxt = mode_r;
					default: rd_data_nxt = 16'h0000;
				endcase
			end
		end
		// Level interrupt from the flags as they stand now
		irq_n_nxt = ~|(status_word & irq_en_r);
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			div3_r <= sensor_status_pkg::DIV3_RESET;
			irq_en_r <= sensor_status_pkg::IRQ_ENABLE_RESET;
			mode_r <= sensor_status_pkg::MODE_RESET;
			source_r <= 2'h0;
			seen_r <= 4'h0;
			rd_data_r <= 16'h0000;
			irq_n_r <= 1'b1;
			sensor_prev_r <= 1'b0;
		end
		else
		begin
			div3_r <= div3_nxt;
			irq_en_r <= irq_en_nxt;
			mode_r <= mode_nxt;
			source_r <= source_nxt;
			seen_r <= seen_nxt;
			rd_data_r <= rd_data_nxt;
			irq_n_r <= irq_n_nxt;
			sensor_prev_r <= sensor3_i;
		end
	end

	// Result words carry no reset: they are only meaningful once a pending bit is set
	always_ff @(posedge clk_i)
	begin
		if (conv_i.done)
		begin
			result_r[conv_i.chan] <= conv_i.data;
		end
	end

	assign rd_data_o = rd_data_r;
	assign interrupt_out_n_o = irq_n_r;

	// ==========================================================
	// Channel 3 dividers
	tick_divider #(
		.WIDTH(sensor_status_pkg::FIN_DIV_W)
	) fin_divider (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.step_i(sensor3_i && !sensor_prev_r),
		.ratio_i(div3_r[sensor_status_pkg::FIN_DIV_LSB +: sensor_status_pkg::FIN_DIV_W]),
		.tick_o(ch3_fin_tick_o)
	);

	tick_divider #(
		.WIDTH(sensor_status_pkg::FREF_DIV_W)
	) fref_divider (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.step_i(1'b1),
		.ratio_i(div3_r[sensor_status_pkg::FREF_DIV_LSB +: sensor_status_pkg::FREF_DIV_W]),
		.tick_o(ch3_fref_tick_o)
	);

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_fin_zero_parks: assert property (
		(div3_r[15:12] == 4'h0) |=> !ch3_fin_tick_o)
		else $error("input divider ticked with a zero ratio");

	a_fref_unit_ratio: assert property (
		(div3_r[9:0] == 10'h001) |=> ch3_fref_tick_o)
		else $error("reference divider of one did not tick every cycle");

	a_source_follows: assert property (
		(err_rep != 6'h00) |=> (status_word[15:14] == $past(conv_i.chan)))
		else $error("source channel not updated on reported error");

	a_read_clears_err: assert property (
		(status_rd && (err_vec == 6'h00)) |=> (status_word[13:8] == 6'h00))
		else $error("status read left error flags set");

	a_err_held: assert property (
		(status_word[13] && !status_rd && !result_rd) |=> status_word[13])
		else $error("under-range flag dropped without a read");

	a_underrange_set: assert property (
		(conv_i.err.underrange && chan_active && irq_en_r[13]) |=> status_word[13])
		else $error("under-range error not reported");

	a_overrange_set: assert property (
		(conv_i.err.overrange && chan_active && irq_en_r[12]) |=> status_word[12])
		else $error("over-range error not reported");

	a_timeout_set: assert property (
		(conv_i.err.timeout && chan_active && irq_en_r[11]) |=> status_word[11])
		else $error("timeout error not reported");

	a_amp_high_set: assert property (
		(conv_i.err.amp_high && chan_active && irq_en_r[10]) |=> status_word[10])
		else $error("amplitude-high error not reported");

	a_amp_low_set: assert property (
		(conv_i.err.amp_low && chan_active && irq_en_r[9]) |=> status_word[9])
		else $error("amplitude-low error not reported");

	a_zero_count_set: assert property (
		(conv_i.err.zero_count && chan_active && irq_en_r[8]) |=> status_word[8])
		else $error("zero-count error not reported");

	a_single_ready: assert property (
		(!seq_mode && conv_i.done && chan_active && irq_en_r[6]) |=> status_word[6])
		else $error("single mode result did not raise ready");

	a_seq_ready_wait: assert property (
		(seq_mode && !seq_complete && !status_word[6]) |=> !status_word[6])
		else $error("sequential ready raised before all active channels");

	a_pending_set: assert property (
		(conv_i.done && chan_active && (conv_i.chan == 2'h0)) |=> status_word[3])
		else $error("channel 0 unread bit not set");

	a_irq_follows: assert property (
		(|(status_word & irq_en_r)) |=> !interrupt_out_n_o)
		else $error("enabled status bit did not raise interrupt");

	a_masked_err_quiet: assert property (
		(!irq_en_r[13] && !status_word[13]) |=> !status_word[13])
		else $error("disabled under-range error reached status");

	a_result_read_clears: assert property (
		(result_rd && (result_ch == 2'h3) && !(conv_i.done && conv_i.chan == 2'h3))
		|=> !status_word[0])
		else $error("channel 3 unread bit survived a result read");

	a_status_write_ignored: assert property (
		(wr_i && addr_i == sensor_status_pkg::STATUS_OFFSET && !conv_i.done && err_vec == 6'h00)
		|=> (status_word == $past(status_word)))
		else $error("status register changed on a write");

endmodule

// [design/tick_divider.sv]
// Event divider: one output tick for every ratio_i input steps
`timescale 1ns/10ps
module tick_divider #(
	parameter int WIDTH = 10
) (
	input wire logic clk_i, // System clock
	input wire logic reset_i, // Synchronous reset, active high
	input wire logic step_i, // One input event
	input wire logic [WIDTH-1:0] ratio_i, // Division ratio, zero holds off
	output logic tick_o // One-cycle output tick
);

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	logic tick_r;
	logic tick_nxt;

	always_comb
	begin
		count_nxt = count_r;
		tick_nxt = 1'b0;
		// Zero is reserved: the divider parks instead of guessing a ratio
		if (ratio_i == '0)
		begin
			count_nxt = '0;
		end
		else if (step_i)
		begin
			// Compare with >= so a ratio lowered mid-count cannot overrun
			if (count_r >= ratio_i - 1'b1)
			begin
				count_nxt = '0;
				tick_nxt = 1'b1;
			end
			else
			begin
				count_nxt = count_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			count_r <= '0;
			tick_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;

endmodule

// [tb/sensor_model.sv]
// Behavioural channel 3 sensor oscillator for the divider tests
`timescale 1ns/10ps
module sensor_model #(
	parameter int HALF = 3
) (
	input wire logic clk_i, // System clock
	input wire logic run_i, // Oscillate while high
	output logic sensor_o // Sensor level
);
	int cnt = 0;

	// ==========================================================
	// Oscillator
	// A period of six clocks keeps the sensor under 8.75 MHz, so dividing by one is legal
	// Parked low when stopped, so no stray edges reach the divider
	always @(posedge clk_i)
	begin
		if (!run_i)
		begin
			cnt <= 0;
			sensor_o <= 1'b0;
		end
		else if (cnt == HALF - 1)
		begin
			cnt <= 0;
			sensor_o <= ~sensor_o;
		end
		else
			cnt <= cnt + 1;
	end
endmodule

// [tb/test_sensor_status_and_clock_divider.sv]
// Register-level testbench for the channel 3 divider and status block
`timescale 1ns/10ps
module test_sensor_status_and_clock_divider;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rd_data;
	sensor_status_pkg::conv_event_type conv = '0;
	logic run = 1'b0;
	logic sensor3;
	logic fin;
	logic fref;
	logic irq_n;
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int n;

	// ==========================================================
	// Design and sensor
	sensor_status_regs dut (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.addr_i(addr),
		.wdata_i(wdata),
		.wr_i(wr),
		.rd_i(rd),
		.rd_data_o(rd_data),
		.conv_i(conv),
		.sensor3_i(sensor3),
		.ch3_fin_tick_o(fin),
		.ch3_fref_tick_o(fref),
		.interrupt_out_n_o(irq_n)
	);

	sensor_model #(.HALF(3)) sensor (
		.clk_i(clk_i),
		.run_i(run),
		.sensor_o(sensor3)
	);

	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	// ==========================================================
	// Tasks
	task check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	task rd_chk(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		check(rd_data, exp);
	endtask

	// Event is held for one cycle; returns on the edge that takes it
	task send(input logic done, input logic [1:0] ch, input logic [5:0] err, input logic [15:0] d);
		@(posedge clk_i);
		conv <= {done, ch, err, d};
		@(posedge clk_i);
		conv <= '0;
	endtask

	task irq_chk(input logic exp);
		@(posedge clk_i);
		#1;
		check({15'h0, irq_n}, {15'h0, exp});
	endtask

	// Cycles between two successive ticks, bounded in case a divider is stuck
	task gap(input logic sel, output int g);
		int k;
		k = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			k++;
		end
		while ((sel ? fin : fref) !== 1'b1 && k < 200);
		g = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			g++;
		end
		while ((sel ? fin : fref) !== 1'b1 && g < 200);
	endtask

	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// Hang guard, well above the few hundred cycles the tests take
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			finish_test;
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		irq_chk(1'b1);
		rd_chk(sensor_status_pkg::DIV3_OFFSET, sensor_status_pkg::DIV3_RESET);
		rd_chk(sensor_status_pkg::STATUS_OFFSET, sensor_status_pkg::STATUS_RESET);
		rd_chk(sensor_status_pkg::IRQ_ENABLE_OFFSET, sensor_status_pkg::IRQ_ENABLE_RESET);
		rd_chk(sensor_status_pkg::MODE_OFFSET, sensor_status_pkg::MODE_RESET);
		rd_chk(8'h20, 16'h0000);
		// Zero ratio is reserved: the reference divider stays silent, so gap runs out
		gap(1'b0, n);
		check(n[15:0], 16'h00c8);
		// Dividers: ratio 2 and 3, then the boundary ratio 1; bits 11:10 kept zero
		wr_reg(sensor_status_pkg::DIV3_OFFSET, 16'h2003);
		rd_chk(sensor_status_pkg::DIV3_OFFSET, 16'h2003);
		gap(1'b0, n);
		check(n[15:0], 16'h0003);
		run <= 1'b1;
		gap(1'b1, n);
		check(n[15:0], 16'h000c);
		wr_reg(sensor_status_pkg::DIV3_OFFSET, 16'h1001);
		gap(1'b1, n);
		check(n[15:0], 16'h0006);
		gap(1'b0, n);
		check(n[15:0], 16'h0001);
		run <= 1'b0;
		// Every error kind, from a rotating source channel
		wr_reg(sensor_status_pkg::MODE_OFFSET, 16'h000f);
		wr_reg(sensor_status_pkg::IRQ_ENABLE_OFFSET, 16'hffff);
		rd_chk(sensor_status_pkg::IRQ_ENABLE_OFFSET, sensor_status_pkg::IRQ_ENABLE_MASK);
		for (int j = 0; j < 6; j++)
		begin
			send(1'b0, j[1:0], 6'h01 << j, 16'h0000);
			irq_chk(1'b0);
			rd_chk(8'h18, {j[1:0], 14'h0} | (16'h0001 << (8 + j)));
			irq_chk(1'b1);
			rd_chk(8'h18, {j[1:0], 14'h0});
		end
		wr_reg(8'h18, 16'hffff);
		rd_chk(8'h18, 16'h4000);
		// Single mode result on channel 2
		send(1'b1, 2'd2, 6'h00, 16'h1234);
		rd_chk(8'h18, 16'h8042);
		rd_chk(8'h02, 16'h1234);
		rd_chk(8'h18, 16'h8000);
		// Sequential mode over channels 0 and 1; channel 2 now inactive
		wr_reg(sensor_status_pkg::MODE_OFFSET, 16'h0013);
		send(1'b1, 2'd0, 6'h00, 16'h00a5);
		send(1'b1, 2'd2, 6'h20, 16'h0000);
		rd_chk(8'h18, 16'h8008);
		send(1'b1, 2'd1, 6'h00, 16'h5a00);
		rd_chk(8'h18, 16'h404c);
		// Reading the source channel's result releases its error
		send(1'b0, 2'd0, 6'h08, 16'h0000);
		rd_chk(8'h00, 16'h00a5);
		rd_chk(8'h18, 16'h0004);
		// Disabled reporting: no flag, no interrupt
		wr_reg(sensor_status_pkg::IRQ_ENABLE_OFFSET, 16'h0000);
		send(1'b0, 2'd1, 6'h20, 16'h0000);
		irq_chk(1'b1);
		rd_chk(8'h18, 16'h0004);
		// Channel 3 result: unread bit 0 sets, then a result read releases it
		wr_reg(sensor_status_pkg::MODE_OFFSET, 16'h0008);
		send(1'b1, 2'd3, 6'h00, 16'hbeef);
		rd_chk(8'h18, 16'h0005);
		rd_chk(8'h03, 16'hbeef);
		rd_chk(8'h18, 16'h0004);
		finish_test;
	end
endmodule
